// file: hw/timer_pkg.sv
// Shared constants, field positions and carrier types of the timer block
package timer_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets (each register is one aligned word)
	localparam logic [7:0] OFS_CSR = 8'h00; // Control and status
	localparam logic [7:0] OFS_LOAD = 8'h04; // Counter load value
	localparam logic [7:0] OFS_CMP = 8'h08; // Compare value
	localparam logic [7:0] OFS_PPL = 8'h0c; // Prescaler preload
	localparam logic [7:0] OFS_CNT = 8'h10; // Counter value, read only
	localparam logic [7:0] OFS_PCNT = 8'h14; // Prescaler count, read only
	localparam logic [7:0] OFS_CTRL = 8'h18; // Enable, mode, source, reload
	localparam logic [7:0] OFS_MASK = 8'h1c; // Interrupt mask, CSR layout
	localparam logic [7:0] OFS_CAP = 8'h20; // Measured count, read only

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CSR_CMP_BIT = 21; // Compare done flag
	localparam int CSR_OVF_BIT = 20; // Counter overflow flag
	localparam int CSR_PCS_BIT = 15; // Prescale clock select
	localparam int PPL_SRC_LO = 21; // Prescale source field, low bit
	localparam int PPL_SRC_HI = 22; // Prescale source field, high bit
	localparam int CTRL_EN_BIT = 0; // Timer enable bit
	localparam int CTRL_MODE_LO = 1; // Operating mode, low bit
	localparam int CTRL_MODE_HI = 2; // Operating mode, high bit
	localparam int CTRL_EXT_BIT = 3; // Count pin edges instead of clk/2
	localparam int CTRL_RELOAD_BIT = 4; // Reload at compare

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [23:0] CSR_RESET = 24'h000000;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [1:0] MASK_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Operating modes and prescaler sources
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h1;
	localparam logic [1:0] MODE_WDOG = 2'h2;
	localparam logic [1:0] MODE_MEAS = 2'h3;
	localparam logic [1:0] SRC_HALF = 2'h0; // Internal clk/2
	localparam logic [1:0] SRC_PIN0 = 2'h1;
	localparam logic [1:0] SRC_PIN1 = 2'h2;
	localparam logic [1:0] SRC_PIN2 = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Bus constants and pin count
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int PIN_COUNT = 3;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} ahb_rsp_t;

	typedef struct packed {
		logic cmp_ack; // Compare interrupt serviced
		logic ovf_ack; // Overflow interrupt serviced
		logic sw_reset; // Software reset instruction
		logic halt; // Halt instruction
	} core_evt_t;

endpackage : timer_pkg

// file: hw/timer_prescaler.sv
// Prescaler counter: one tick per preload plus one source events
`timescale 1ns/10ps
module timer_prescaler #(
	parameter int PRE_W = 21
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic run,
	input wire logic [1:0] src_sel,
	input wire logic [PRE_W-1:0] preload,
	// Source events, one cycle each
	input wire logic half_tick,
	input wire logic [timer_pkg::PIN_COUNT-1:0] pin_rise,
	// Results
	output logic tick,
	output logic [PRE_W-1:0] count
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Source selection
	logic src_evt; // One source event this cycle
	assign src_evt = (src_sel == SRC_HALF) ? half_tick :
		(src_sel == SRC_PIN0) ? pin_rise[0] :
		(src_sel == SRC_PIN1) ? pin_rise[1] : pin_rise[2];

	logic at_zero; // Last event of a period
	assign at_zero = (count == '0);

	////////////////////////////////////////////////////////////////////////
	// Down counter, reloaded while stopped and after each period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			// Stopped: park on the preload value
			count <= preload;
			tick <= 1'b0;
		end else if (src_evt) begin
			// Count down, tick on the event that finds zero
			count <= at_zero ? preload : count - PRE_W'(1);
			tick <= at_zero;
		end else begin
			tick <= 1'b0;
		end
	end

endmodule : timer_prescaler

// file: hw/timer_block.sv
// Timer counter with sticky flags, prescaler and AHB-Lite register slave
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Count modes flag compare after M-N+1 events
// - Measurement mode flags compare when measurement ends
// - Writing one clears compare flag; zero ignored
// - Servicing compare interrupt clears compare flag
// - Reset, soft reset, halt, disable clear compare
// - Counter overflow sets overflow flag
// - Writing one clears overflow flag; zero ignored
// - Servicing overflow interrupt clears overflow flag
// - Reset, soft reset, halt, disable clear overflow
// - Select bit set: prescaler clocks the counter
// - Select bit clear: clk/2 or pin clocks
// - Preload source field picks prescaler source
// - Prescaler may use another timer's pin
// - Reserved bits read zero, written zero
module timer_block #(
	parameter int COUNT_W = 24,
	parameter int PRE_W = 21
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register bus
	input wire timer_pkg::ahb_req_t bus_req,
	output timer_pkg::ahb_rsp_t bus_rsp,
	// Core events, same clock
	input wire timer_pkg::core_evt_t core_evt,
	// Timer pins: own pin first, then the other timers' pins
	input wire logic [timer_pkg::PIN_COUNT-1:0] timer_io_pin,
	// Interrupt
	output logic irq
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (COUNT_W < 8 || COUNT_W > 24) begin : g_bad_count
		$error("COUNT_W must lie in 8..24");
	end
	if (PRE_W < 1 || PRE_W > 21) begin : g_bad_pre
		$error("PRE_W must lie in 1..21");
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	// Word-aligned offset match, used by read and write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a[7:2] == o[7:2]);
	endfunction : hit

	// Zero extend a counter-wide value to a bus word
	function automatic logic [31:0] ext_c(input logic [COUNT_W-1:0] v);
		ext_c = {{(32-COUNT_W){1'b0}}, v};
	endfunction : ext_c

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] addr_q; // Address of the data phase
	logic wr_q; // Write data phase pending
	logic rd_q; // Read data phase pending
	logic ready_q; // hreadyout
	logic [31:0] rdata_q; // hrdata
	logic irq_q; // Interrupt output
	logic cmp_flag_q; // compare_done_flag
	logic ovf_flag_q; // counter_overflow_flag
	logic pcs_q; // prescale_clock_select
	logic [COUNT_W-1:0] load_q; // counter_load_value
	logic [COUNT_W-1:0] cmp_q; // Compare value
	logic [1:0] psrc_q; // prescale_source_field
	logic [PRE_W-1:0] ppl_q; // Prescaler preload value
	logic [4:0] ctrl_q; // Enable, mode, source, reload
	logic [1:0] mask_q; // Mask for compare (1) and overflow (0)
	logic [COUNT_W-1:0] cnt_q; // Counter
	logic [COUNT_W-1:0] cap_q; // Count at last measurement end
	logic half_q; // Clock divider for clk/2
	logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q; // Pin synchronisers
	logic [PIN_COUNT-1:0] pin_q; // Filtered pin level
	logic pre_tick; // Prescaler tick, one cycle
	logic [PRE_W-1:0] pcount; // Prescaler count

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic accept; // Address phase taken
	assign accept = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;

	logic wr_csr, wr_load, wr_cmp, wr_ppl, wr_ctrl, wr_mask;
	assign wr_csr = wr_q && hit(addr_q, OFS_CSR);
	assign wr_load = wr_q && hit(addr_q, OFS_LOAD);
	assign wr_cmp = wr_q && hit(addr_q, OFS_CMP);
	assign wr_ppl = wr_q && hit(addr_q, OFS_PPL);
	assign wr_ctrl = wr_q && hit(addr_q, OFS_CTRL);
	assign wr_mask = wr_q && hit(addr_q, OFS_MASK);

	logic [31:0] wd; // Write data of the data phase
	assign wd = bus_req.hwdata;

	////////////////////////////////////////////////////////////////////////
	// Control field decode
	logic enable; // timer_enable_bit
	logic [1:0] mode;
	logic ext_src, reload, meas;
	assign enable = ctrl_q[CTRL_EN_BIT];
	assign mode = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
	assign ext_src = ctrl_q[CTRL_EXT_BIT];
	assign reload = ctrl_q[CTRL_RELOAD_BIT];
	assign meas = (mode == MODE_MEAS);

	////////////////////////////////////////////////////////////////////////
	// Read image; reserved bits read zero
	logic [31:0] csr_img, rd_mux;
	assign csr_img = {8'h00, 2'b00, cmp_flag_q, ovf_flag_q, 4'h0,
		pcs_q, 1'b0, 14'h0000};
	assign rd_mux = hit(addr_q, OFS_CSR) ? csr_img :
		hit(addr_q, OFS_LOAD) ? ext_c(load_q) :
		hit(addr_q, OFS_CMP) ? ext_c(cmp_q) :
		hit(addr_q, OFS_PPL) ? {9'h000, psrc_q, 21'(ppl_q)} :
		hit(addr_q, OFS_CNT) ? ext_c(cnt_q) :
		hit(addr_q, OFS_PCNT) ? {{(32-PRE_W){1'b0}}, pcount} :
		hit(addr_q, OFS_CTRL) ? {27'h0000000, ctrl_q} :
		hit(addr_q, OFS_MASK) ? {10'h000, mask_q, 20'h00000} :
		hit(addr_q, OFS_CAP) ? ext_c(cap_q) : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: writes take no wait state, reads one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ready_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else if (rd_q) begin
			// Read data phase: drive data, release the bus
			rdata_q <= rd_mux;
			ready_q <= 1'b1;
			rd_q <= 1'b0;
		end else begin
			// Idle or write data phase: may take a new address
			wr_q <= accept && bus_req.hwrite;
			rd_q <= accept && !bus_req.hwrite;
			ready_q <= !(accept && !bus_req.hwrite);
			if (accept) begin
				addr_q <= bus_req.haddr[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain control registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pcs_q <= CSR_RESET[CSR_PCS_BIT];
			load_q <= WORD_RESET[COUNT_W-1:0];
			cmp_q <= WORD_RESET[COUNT_W-1:0];
			psrc_q <= WORD_RESET[PPL_SRC_HI:PPL_SRC_LO];
			ppl_q <= WORD_RESET[PRE_W-1:0];
			ctrl_q <= CTRL_RESET;
			mask_q <= MASK_RESET;
		end else begin
			if (wr_csr) pcs_q <= wd[CSR_PCS_BIT];
			if (wr_load) load_q <= wd[COUNT_W-1:0];
			if (wr_cmp) cmp_q <= wd[COUNT_W-1:0];
			if (wr_ppl) begin
				psrc_q <= wd[PPL_SRC_HI:PPL_SRC_LO];
				ppl_q <= wd[PRE_W-1:0];
			end
			if (wr_ctrl) ctrl_q <= wd[4:0];
			if (wr_mask) mask_q <= {wd[CSR_CMP_BIT], wd[CSR_OVF_BIT]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree
	logic [PIN_COUNT-1:0] agree, pin_rise;
	assign agree = ~(s2_q ^ s3_q);
	assign pin_rise = agree & s3_q & ~pin_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= timer_io_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (agree & s3_q) | (~agree & pin_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock divider: one-cycle enable every second clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler; any timer pin can feed it
	timer_prescaler #(
		.PRE_W(PRE_W)
	) u_prescaler (
		.clk(clk),
		.reset_n(reset_n),
		.run(enable && pcs_q),
		.src_sel(psrc_q),
		.preload(ppl_q),
		.half_tick(half_q),
		.pin_rise(pin_rise),
		.tick(pre_tick),
		.count(pcount)
	);

	////////////////////////////////////////////////////////////////////////
	// Counter source: prescaler wins over clk/2 and pin in every mode
	logic cnt_evt;
	assign cnt_evt = pcs_q ? pre_tick :
		(ext_src ? pin_rise[0] : half_q);

	////////////////////////////////////////////////////////////////////////
	// Counter sequencing
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} cnt_state_t;
	cnt_state_t state_q, state_d;

	logic running, cnt_full, at_cmp, cmp_set, ovf_set, meas_done;
	logic [COUNT_W-1:0] cnt_inc, cnt_d;
	assign running = (state_q == ST_RUN);
	assign cnt_full = &cnt_q;
	assign at_cmp = (cnt_q == cmp_q);
	assign cnt_inc = cnt_q + COUNT_W'(1);
	// Load event counts as the first, so M is reached on event M-N+1;
	// judging the next count lets a load or reload equal to M flag too
	assign cmp_set = (cnt_evt && !meas &&
		state_q != ST_IDLE && cnt_d == cmp_q) || meas_done;
	assign meas_done = running && meas && pin_rise[0];
	assign ovf_set = running && cnt_evt && cnt_full;

	// Next state and count
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			ST_IDLE: begin
				if (enable) state_d = ST_ARMED;
			end
			ST_ARMED: begin
				// First event after enable loads the load value
				if (cnt_evt) begin
					cnt_d = load_q;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (meas_done && reload) begin
					cnt_d = load_q;
				end else if (cnt_evt) begin
					if (cnt_full) begin
						// PWM restarts from the load value on overflow
						cnt_d = (mode == MODE_PWM) ? load_q : '0;
					end else if (at_cmp && reload && !meas &&
						mode != MODE_PWM) begin
						cnt_d = load_q;
					end else begin
						cnt_d = cnt_inc;
					end
				end
			end
		endcase
		if (!enable) state_d = ST_IDLE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			cap_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (meas_done) cap_q <= cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags
	logic flag_kill, cmp_clr, ovf_clr;
	// Soft reset, halt and disable clear both flags outright
	assign flag_kill = core_evt.sw_reset || core_evt.halt || !enable;
	assign cmp_clr = (wr_csr && wd[CSR_CMP_BIT]) ||
		core_evt.cmp_ack;
	assign ovf_clr = (wr_csr && wd[CSR_OVF_BIT]) ||
		core_evt.ovf_ack;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmp_flag_q <= CSR_RESET[CSR_CMP_BIT];
			ovf_flag_q <= CSR_RESET[CSR_OVF_BIT];
		end else begin
			// Compare flag: kill, then set beats clear
			if (flag_kill) cmp_flag_q <= 1'b0;
			else if (cmp_set) cmp_flag_q <= 1'b1;
			else if (cmp_clr) cmp_flag_q <= 1'b0;
			// Overflow flag, same priority
			if (flag_kill) ovf_flag_q <= 1'b0;
			else if (ovf_set) ovf_flag_q <= 1'b1;
			else if (ovf_clr) ovf_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt: high while an unmasked flag is set
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |({cmp_flag_q, ovf_flag_q} & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign irq = irq_q;
	assign bus_rsp.hreadyout = ready_q;
	assign bus_rsp.hresp = HRESP_OKAY;
	assign bus_rsp.hrdata = rdata_q;

endmodule : timer_block

// file: tb/timer_block_monitor.sv
// Port checker for the timer block
`timescale 1ns/10ps
module timer_block_monitor #(
	parameter int COUNT_W = 24,
	parameter int PRE_W = 21
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus, core events, pins, interrupt
	input wire timer_pkg::ahb_req_t bus_req,
	input wire timer_pkg::ahb_rsp_t bus_rsp,
	input wire timer_pkg::core_evt_t core_evt,
	input wire logic [timer_pkg::PIN_COUNT-1:0] timer_io_pin,
	input wire logic irq
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Shadow of the bus phases and of control and mask writes
	logic wp_q, rp_q;
	logic [7:0] wa_q;
	logic [4:0] ctl_q;
	logic [1:0] msk_q;
	wire take = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
	wire wr_ctl = wp_q && wa_q == OFS_CTRL;
	wire wr_msk = wp_q && wa_q == OFS_MASK;
	wire csr_rd = rp_q && bus_rsp.hreadyout && wa_q == OFS_CSR;
	wire ovf_wc = wp_q && wa_q == OFS_CSR && bus_req.hwdata[20];

	// Phase tracking follows hreadyout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			wa_q <= 8'h00;
			ctl_q <= 5'h00;
			msk_q <= 2'h0;
		end else begin
			if (bus_rsp.hreadyout) begin
				wp_q <= take && bus_req.hwrite;
				rp_q <= take && !bus_req.hwrite;
				wa_q <= bus_req.haddr[7:0];
			end
			if (wr_ctl) ctl_q <= bus_req.hwdata[4:0];
			if (wr_msk) msk_q <= bus_req.hwdata[21:20];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_meas;
		$rose(timer_io_pin[0]) && ctl_q == 5'h07 && msk_q == 2'h2
			|-> ##[3:8] irq;
	endproperty
	property p_cmp_ack;
		core_evt.cmp_ack && msk_q == 2'h2 && ctl_q[2:1] != MODE_MEAS
			|-> ##2 !irq;
	endproperty
	property p_ovf_ack;
		core_evt.ovf_ack && msk_q == 2'h1 |-> ##2 !irq;
	endproperty
	property p_halt;
		core_evt.halt |-> ##2 !irq;
	endproperty
	property p_swrst;
		core_evt.sw_reset |-> ##2 !irq;
	endproperty
	property p_w1c;
		ovf_wc && msk_q == 2'h1 |-> ##2 !irq;
	endproperty
	property p_dis;
		(!ctl_q[0]) [*3] |-> !irq;
	endproperty
	property p_rsv;
		csr_rd |-> (bus_rsp.hrdata & 32'hffcf7fff) == 32'h0;
	endproperty

	a_meas: assert property (p_meas)
		else $error("no interrupt after measurement edge");
	a_cmp_ack: assert property (p_cmp_ack)
		else $error("compare flag kept after service");
	a_ovf_ack: assert property (p_ovf_ack)
		else $error("overflow flag kept after service");
	a_halt: assert property (p_halt)
		else $error("flags kept after halt");
	a_swrst: assert property (p_swrst)
		else $error("flags kept after soft reset");
	a_w1c: assert property (p_w1c)
		else $error("overflow flag kept after write one");
	a_dis: assert property (p_dis)
		else $error("interrupt while timer disabled");
	a_rsv: assert property (p_rsv)
		else $error("reserved status bits read nonzero");

	// Main scenarios reached
	c_csr: cover property (csr_rd);
	c_halt: cover property (core_evt.halt);
	c_irq: cover property ($rose(irq));
endmodule : timer_block_monitor

bind timer_block timer_block_monitor #(.COUNT_W(COUNT_W), .PRE_W(PRE_W))
	u_mon (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
	.bus_rsp(bus_rsp), .core_evt(core_evt),
	.timer_io_pin(timer_io_pin), .irq(irq));

// file: tb/pin_model.sv
// Outside driver of the timer pins
`timescale 1ns/10ps
module pin_model (
	// Clock
	input wire logic clk,
	// Pin levels
	output logic [timer_pkg::PIN_COUNT-1:0] pin
);
	initial pin = '0;

	// Rising edges on one pin, slow enough for the synchroniser
	task automatic rise(input int idx, input int n);
		repeat (n) begin
			pin[idx] <= 1'b1;
			repeat (4) @(posedge clk);
			pin[idx] <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask : rise
endmodule : pin_model

// file: tb/tb.sv
// Self-checking bench of the timer block
`timescale 1ns/10ps
module tb;
	import timer_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	ahb_req_t m, rqw;
	ahb_rsp_t rs;
	core_evt_t ev;
	logic [PIN_COUNT-1:0] pin;
	logic irq;
	logic rdp = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 40975;
	logic [31:0] expq[$];

	always #20 clk = ~clk;
	// Single slave: its hreadyout is the bus hready
	always_comb begin
		rqw = m;
		rqw.hready = rs.hreadyout;
	end

	timer_block dut (.clk(clk), .reset_n(reset_n), .bus_req(rqw),
		.bus_rsp(rs), .core_evt(ev), .timer_io_pin(pin), .irq(irq));
	pin_model pm (.clk(clk), .pin(pin));

	////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic final_report();
		if (expq.size() != 0) error_cnt++;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// Read data checked against the oldest note when it completes
	always @(posedge clk) begin
		if (rdp && rs.hreadyout) begin
			chk("hresp", {31'h0, rs.hresp}, {31'h0, HRESP_OKAY});
			if (expq.size() == 0) chk("queue", 32'h1, 32'h0);
			else chk("hrdata", rs.hrdata, expq.pop_front());
		end
		if (rs.hreadyout) rdp <= m.hsel && m.htrans[1] && !m.hwrite;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus and event tasks
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		m.hsel <= 1'b1;
		m.htrans <= HTRANS_NONSEQ;
		m.haddr <= {24'h0, a};
		m.hwrite <= w;
		m.hsize <= 3'h2;
		do begin
			@(posedge clk);
			n++;
		end while (!rs.hreadyout && n < 50);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (!rs.hreadyout && n < 50);
		if (n >= 50) begin
			chk("timeout", 32'h0, 32'h1);
			final_report();
		end
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// Bounded wait for the interrupt level
	task automatic wirq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("irq", {31'h0, irq}, {31'h0, v});
		if (n >= 100) final_report();
	endtask : wirq

	// Order: cmp_ack, ovf_ack, sw_reset, halt
	task automatic evp(input logic [3:0] e);
		ev <= e;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask : evp

	task automatic arm();
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wirq(1'b1);
	endtask : arm

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] d;
		m = '0;
		ev = '0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(OFS_CSR, 32'h0);
		rd(8'h24, 32'h0);
		d = $random(seed);
		wr(OFS_CSR, d);
		rd(OFS_CSR, d & 32'h8000);
		wr(OFS_CSR, 32'h0);
		$display("test registers done");
		wr(OFS_LOAD, 32'h5);
		wr(OFS_CMP, 32'h9);
		wr(OFS_MASK, 32'h200000);
		wr(OFS_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		wirq(1'b1);
		wr(OFS_CSR, 32'h100000);
		rd(OFS_CSR, 32'h200000);
		wr(OFS_CSR, 32'h200000);
		wirq(1'b0);
		rd(OFS_CSR, 32'h0);
		arm();
		evp(4'h8);
		wirq(1'b0);
		$display("test compare done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_LOAD, 32'hfffffd);
		wr(OFS_CMP, 32'h800000);
		wr(OFS_MASK, 32'h100000);
		wr(OFS_CTRL, 32'h1);
		wirq(1'b1);
		wr(OFS_CSR, 32'h200000);
		rd(OFS_CSR, 32'h100000);
		wr(OFS_CSR, 32'h100000);
		wirq(1'b0);
		arm();
		evp(4'h4);
		wirq(1'b0);
		for (int i = 0; i < 2; i++) begin
			arm();
			evp(i ? 4'h1 : 4'h2);
			wirq(1'b0);
		end
		arm();
		wr(OFS_CTRL, 32'h0);
		wirq(1'b0);
		$display("test overflow done");
		wr(OFS_CSR, 32'h8000);
		wr(OFS_PPL, 32'h400001);
		wr(OFS_LOAD, 32'h0);
		wr(OFS_CMP, 32'h1);
		wr(OFS_MASK, 32'h200000);
		wr(OFS_CTRL, 32'h1);
		pm.rise(1, 3);
		chk("irq", {31'h0, irq}, 32'h0);
		pm.rise(1, 1);
		wirq(1'b1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CSR, 32'h0);
		wr(OFS_CTRL, 32'h7);
		repeat (20) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		pm.rise(0, 1);
		wirq(1'b1);
		$display("test prescaler and measure done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_LOAD, 32'h2);
		wr(OFS_CMP, 32'h3);
		wr(OFS_CTRL, 32'h19);
		pm.rise(0, 2);
		wirq(1'b1);
		rd(OFS_CNT, 32'h3);
		wr(OFS_CSR, 32'h200000);
		wirq(1'b0);
		pm.rise(0, 2);
		wirq(1'b1);
		rd(OFS_CNT, 32'h3);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(OFS_CSR, 32'h0);
		$display("test pin count and reset done");
		repeat (2) @(posedge clk);
		final_report();
	end
endmodule : tb
